/* File: hdl/acg_defs.vh */
/*
  Constants for the converter global setup block: register indices,
  field positions, power-on values and timing counts.
  Assumes it is included by bare name from the design files.
*/
`ifndef ACG_DEFS_VH
`define ACG_DEFS_VH

// Register indices (byte address = 4 * index)
`define ACG_IDX_SETUP       8'h0d
`define ACG_IDX_OFFSET_BASE 8'h0f
`define ACG_IDX_STATUS      8'h20

// Field positions inside the setup word
`define ACG_BIT_OFFCORR     23
`define ACG_BIT_GAINCORR    22
`define ACG_IDLE_TONE_SCRAMBLE_LEVEL_HI       21
`define ACG_IDLE_TONE_SCRAMBLE_LEVEL_LO       20
`define ACG_BIAS_HI         19
`define ACG_BIAS_LO         18
`define ACG_PRE_HI          17
`define ACG_PRE_LO          16
`define ACG_OSR_HI          15
`define ACG_OSR_LO          13
`define ACG_TRIM_HI         7
`define ACG_TRIM_LO         0

// Implemented bits of the setup word; 12..8 always read zero
`define ACG_SETUP_MASK      24'hffe0ff
`define ACG_SETUP_RESET     24'h386050

// Timing: gain correction delay in digital master clock periods
`define ACG_GAIN_DELAY      5'h18
// Smallest oversampling ratio, larger ratios double from it
`define ACG_OSR_MIN         13'h0020

// Bus answers
`define ACG_RESP_OKAY       2'h0
`define ACG_RESP_SLVERR     2'h2

`endif

/* File: hdl/acg_offset_adder.v */
/*
  One channel of digital offset correction: adds the stored offset to
  the raw converter code when enabled, purely combinational.
  Assumes the caller registers the result at its data-ready point.
*/
`timescale 1ns/1ps

module acg_offset_adder (
  // Operands
  input  wire [23:0] rawCode,     // Raw converter code, two's complement
  input  wire [23:0] offsetValue, // Channel offset, two's complement
  input  wire        enable,      // Offset correction on
  // Result
  output wire [23:0] sumCode      // Corrected code
);

  // Wraps modulo 2^24, same as a plain bit-by-bit addition; no group delay
  assign sumCode = enable ? (rawCode + offsetValue) : rawCode;

endmodule

/* File: hdl/acg_converter_global_setup.v */
/*
  Global setup register of an eight-channel delta-sigma front end, with
  an AXI4-Lite slave, analog clock prescaler, data-rate divider, gain
  correction delay and per-channel offset correction.
  Assumes raw codes come from logic on clk, one word per channel.
*/
// The placing of the registers and register access over AXI4-Lite were chosen for this implementation.
// Function
// - Offset enable adds offset, no delay, default off
// - Gain enable delays data ready 24 periods
// - Idle_tone_scramble_level field decodes max, medium, min, off
// - Bias field selects x2, x1, x0.66, x0.5
// - Prescaler divides analog clock by 1,2,4,8
// - Ratio 32 to 4096 sets output rate
// - Low byte is read-write reference trim
// - Unimplemented middle bits read as zero
// - Corrected code is raw plus channel offset while offset is enabled, raw alone otherwise
`timescale 1ns/1ps
`include "acg_defs.vh"

module acg_converter_global_setup (
  // Clock and reset
  input  wire         clk,
  input  wire         nrst,
  // AXI4-Lite write address
  input  wire [31:0]  s_axi_awaddr,
  input  wire         s_axi_awvalid,
  output wire         s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0]  s_axi_wdata,
  input  wire [3:0]   s_axi_wstrb,
  input  wire         s_axi_wvalid,
  output wire         s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]   s_axi_bresp,
  output reg          s_axi_bvalid,
  input  wire         s_axi_bready,
  // AXI4-Lite read address
  input  wire [31:0]  s_axi_araddr,
  input  wire         s_axi_arvalid,
  output wire         s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0]  s_axi_rdata,
  output reg  [1:0]   s_axi_rresp,
  output reg          s_axi_rvalid,
  input  wire         s_axi_rready,
  // Converter side
  input  wire [191:0] rawCodes,          // Eight raw codes, channel 0 lowest
  output reg  [191:0] correctedCodes,    // Eight corrected codes
  output reg          dataReadyPulse,    // One cycle per output word
  output reg          analogMasterClkEn, // Analog clock enable pulse
  // Decoded analog settings
  output wire         ditherOn,          // Dithering active
  output wire [1:0]   ditherStrength,    // 3 max, 2 medium, 1 min
  output wire [1:0]   biasCurrentSelect, // Bias scale code
  output wire [7:0]   referenceTrim      // Reference tempco trim
);

  ////////////////////////////////////////////////////////////////////////
  // Register storage
  reg  [23:0]  setup_q;       // Global setup word
  reg  [191:0] offsets_q;     // Channel offset values
  reg  [2:0]   preCnt_q;      // Prescaler counter
  reg  [12:0]  osrCnt_q;      // Sampling clock counter
  reg  [4:0]   gainCnt_q;     // Gain delay countdown
  reg          gainPending_q; // Delayed ready is waiting
  reg          awHeld_q;      // Write address captured
  reg          wHeld_q;       // Write data captured
  reg  [31:0]  awAddr_q;      // Captured write address
  reg  [31:0]  wData_q;       // Captured write data
  reg  [3:0]   wStrb_q;       // Captured byte strobes

  // Field views
  wire         offCorrEn  = setup_q[`ACG_BIT_OFFCORR];
  wire         gainCorrEn = setup_q[`ACG_BIT_GAINCORR];
  wire [1:0]   preSel     = setup_q[`ACG_PRE_HI:`ACG_PRE_LO];
  wire [2:0]   osrSel     = setup_q[`ACG_OSR_HI:`ACG_OSR_LO];

  // Idle_tone_scramble_level: 00 off, otherwise strength follows the code
  assign ditherOn          = |setup_q[`ACG_IDLE_TONE_SCRAMBLE_LEVEL_HI:`ACG_IDLE_TONE_SCRAMBLE_LEVEL_LO];
  assign ditherStrength    = setup_q[`ACG_IDLE_TONE_SCRAMBLE_LEVEL_HI:`ACG_IDLE_TONE_SCRAMBLE_LEVEL_LO];
  // 11 x2, 10 x1, 01 x0.66, 00 x0.5
  assign biasCurrentSelect = setup_q[`ACG_BIAS_HI:`ACG_BIAS_LO];
  assign referenceTrim     = setup_q[`ACG_TRIM_HI:`ACG_TRIM_LO];

  ////////////////////////////////////////////////////////////////////////
  // Write channel: address and data taken in either order
  assign s_axi_awready = !awHeld_q && !s_axi_bvalid;
  assign s_axi_wready  = !wHeld_q && !s_axi_bvalid;

  wire       doWrite  = awHeld_q && wHeld_q;
  wire [7:0] wIdx     = awAddr_q[9:2];
  wire       wInRange = (awAddr_q[31:10] == 22'h000000) && (awAddr_q[1:0] == 2'h0);
  wire       wSetup   = wInRange && (wIdx == `ACG_IDX_SETUP);
  wire       wStatus  = wInRange && (wIdx == `ACG_IDX_STATUS);
  // Offset registers sit on every second index from the base
  wire [7:0] wOffRel  = wIdx - `ACG_IDX_OFFSET_BASE;
  wire       wOffset  = wInRange && !wOffRel[0] && (wOffRel[7:4] == 4'h0);
  wire [2:0] wChan    = wOffRel[3:1];

  // Byte strobes widened to a 24-bit lane mask
  wire [23:0] laneMask = {{8{wStrb_q[2]}}, {8{wStrb_q[1]}}, {8{wStrb_q[0]}}};

  // Capture, write and respond
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      awHeld_q     <= 1'b0;
      wHeld_q      <= 1'b0;
      awAddr_q     <= 32'h00000000;
      wData_q      <= 32'h00000000;
      wStrb_q      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `ACG_RESP_OKAY;
      setup_q      <= `ACG_SETUP_RESET;
      offsets_q    <= 192'h0;
    end else begin
      // Address capture
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end
      // Data capture
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      // Both halves present: commit and answer
      if (doWrite) begin
        awHeld_q     <= 1'b0;
        wHeld_q      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wSetup || wOffset || wStatus) ? `ACG_RESP_OKAY : `ACG_RESP_SLVERR;
        // Masked merge keeps unimplemented bits at zero
        if (wSetup) begin
          setup_q <= ((setup_q & ~laneMask) | (wData_q[23:0] & laneMask))
                     & `ACG_SETUP_MASK;
        end
        // Offset kept even while correction is off
        if (wOffset) begin
          offsets_q[wChan*24 +: 24] <= (offsets_q[wChan*24 +: 24] & ~laneMask)
                                       | (wData_q[23:0] & laneMask);
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read channel: one cycle from address to data
  assign s_axi_arready = !s_axi_rvalid;

  wire [7:0] rIdx     = s_axi_araddr[9:2];
  wire       rInRange = (s_axi_araddr[31:10] == 22'h000000) && (s_axi_araddr[1:0] == 2'h0);
  wire [7:0] rOffRel  = rIdx - `ACG_IDX_OFFSET_BASE;
  wire       rOffset  = rInRange && !rOffRel[0] && (rOffRel[7:4] == 4'h0);
  wire [2:0] rChan    = rOffRel[3:1];

  // Read mux and answer
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `ACG_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `ACG_RESP_OKAY;
      if (rInRange && (rIdx == `ACG_IDX_SETUP)) begin
        s_axi_rdata <= {8'h00, setup_q & `ACG_SETUP_MASK};
      end else if (rOffset) begin
        s_axi_rdata <= {8'h00, offsets_q[rChan*24 +: 24]};
      end else if (rInRange && (rIdx == `ACG_IDX_STATUS)) begin
        // Live divider state for software
        s_axi_rdata <= {10'h000, gainCnt_q, gainPending_q, osrCnt_q, preCnt_q};
      end else begin
        // Unmapped: zero data, slave error
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= `ACG_RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Analog clock prescaler and output-rate divider
  wire [3:0]  preDiv   = 4'h1 << preSel;               // 1, 2, 4 or 8
  wire [12:0] osrRatio = `ACG_OSR_MIN << osrSel;       // 32 .. 4096
  wire        preWrap  = ({1'b0, preCnt_q} >= (preDiv - 4'h1));
  wire        osrWrap  = (osrCnt_q >= (osrRatio - 13'h0001));
  // Raw ready: one output word per ratio sampling clocks
  wire        rawReady = analogMasterClkEn && osrWrap;

  // Counters; compares use >= so a smaller setting never strands them
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      preCnt_q          <= 3'h0;
      analogMasterClkEn <= 1'b0;
      osrCnt_q          <= 13'h0000;
    end else begin
      analogMasterClkEn <= preWrap;
      preCnt_q          <= preWrap ? 3'h0 : preCnt_q + 3'h1;
      if (analogMasterClkEn) begin
        osrCnt_q <= osrWrap ? 13'h0000 : osrCnt_q + 13'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Gain correction group delay and output registers
  // Delay counts digital clock periods, taken equal to analog clock ticks
  wire gainFire = gainPending_q && analogMasterClkEn && (gainCnt_q == 5'h01);
  wire emit     = gainCorrEn ? gainFire : rawReady;

  wire [191:0] sums; // Combinational corrected codes

  genvar ch;
  generate
    for (ch = 0; ch < 8; ch = ch + 1) begin : gChan
      acg_offset_adder uAdd (
        .rawCode     (rawCodes[ch*24 +: 24]),
        .offsetValue (offsets_q[ch*24 +: 24]),
        .enable      (offCorrEn),
        .sumCode     (sums[ch*24 +: 24])
      );
    end
  endgenerate

  // Delay countdown and output capture
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gainCnt_q      <= 5'h00;
      gainPending_q  <= 1'b0;
      dataReadyPulse <= 1'b0;
      correctedCodes <= 192'h0;
    end else begin
      dataReadyPulse <= emit;
      if (gainCorrEn && rawReady) begin
        // New word restarts the 24-period delay
        gainPending_q <= 1'b1;
        gainCnt_q     <= `ACG_GAIN_DELAY;
      end else if (gainFire || !gainCorrEn) begin
        gainPending_q <= 1'b0;
        gainCnt_q     <= 5'h00;
      end else if (gainPending_q && analogMasterClkEn) begin
        gainCnt_q <= gainCnt_q - 5'h01;
      end
      // Offset path adds no extra cycle
      if (emit) begin
        correctedCodes <= sums;
      end
    end
  end

endmodule

/* File: test/acg_setup_properties.sv */
/*
  Checker for the converter global setup block: bus answers, decoded
  field outputs, setup readback and data-ready timing.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps
`include "acg_defs.vh"

module acg_setup_checker (
  // Clock and reset
  input wire         clk,
  input wire         nrst,
  // Bus handshakes
  input wire [31:0]  s_axi_araddr,
  input wire         s_axi_arvalid,
  input wire         s_axi_arready,
  input wire [31:0]  s_axi_rdata,
  input wire         s_axi_rvalid,
  input wire         s_axi_awvalid,
  input wire         s_axi_awready,
  input wire         s_axi_wvalid,
  input wire         s_axi_wready,
  input wire         s_axi_bvalid,
  input wire [1:0]   s_axi_bresp,
  // Converter side
  input wire [191:0] correctedCodes,
  input wire         dataReadyPulse,
  input wire         ditherOn,
  input wire [1:0]   ditherStrength,
  input wire [1:0]   biasCurrentSelect,
  input wire [7:0]   referenceTrim
);
  ////////////////////////////////////////////////////////////////////////
  // Remembers whether the pending read targets the setup word
  reg rdSetup_q;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdSetup_q <= 1'b0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rdSetup_q <= (s_axi_araddr == {22'h0, `ACG_IDX_SETUP, 2'h0});
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  ////////////////////////////////////////////////////////////////////////
  property p_idle_tone_scramble_level_on; ditherOn == (ditherStrength != 2'h0); endproperty
  a_idle_tone_scramble_level_on: assert property (p_idle_tone_scramble_level_on)
    else $error("idle_tone_scramble_level enable disagrees with strength");
  property p_trim_read; s_axi_rvalid && rdSetup_q |-> s_axi_rdata[7:0] == referenceTrim; endproperty
  a_trim_read: assert property (p_trim_read)
    else $error("trim readback differs from trim output");
  property p_gap_zero; s_axi_rvalid && rdSetup_q |-> s_axi_rdata[12:8] == 5'h0 && s_axi_rdata[31:24] == 8'h0;
  endproperty
  a_gap_zero: assert property (p_gap_zero)
    else $error("unused setup bits read nonzero");
  property p_field_read; s_axi_rvalid && rdSetup_q |-> s_axi_rdata[21:18] == {ditherStrength, biasCurrentSelect};
  endproperty
  a_field_read: assert property (p_field_read)
    else $error("idle_tone_scramble_level or bias readback differs from outputs");
  // Shortest output period is far above four cycles
  property p_pulse_single; dataReadyPulse |=> !dataReadyPulse [*4]; endproperty
  a_pulse_single: assert property (p_pulse_single)
    else $error("data ready pulse repeated too soon");
  property p_codes_hold; $changed(correctedCodes) |-> dataReadyPulse; endproperty
  a_codes_hold: assert property (p_codes_hold)
    else $error("corrected codes moved without data ready");
  property p_wr_resp; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_wr_resp: assert property (p_wr_resp)
    else $error("write response late");
  property p_rd_resp; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rd_resp: assert property (p_rd_resp)
    else $error("read data late");
  // Main scenarios reached
  c_pulse: cover property (dataReadyPulse);
  c_setup_read: cover property (s_axi_rvalid && rdSetup_q);
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule

bind acg_converter_global_setup acg_setup_checker u_acg_setup_checker (.clk, .nrst, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bresp, .correctedCodes, .dataReadyPulse, .ditherOn, .ditherStrength, .biasCurrentSelect,
  .referenceTrim);

/* File: test/testbench.sv */
/*
  Self-checking bench for the converter global setup block: register
  access, field outputs, prescaler, data rate and corrections.
  Assumes the checker file is compiled alongside and binds itself.
*/
`timescale 1ns/1ps

module testbench;
  reg          clk = 1'b0;
  reg          nrst = 1'b0;
  reg  [31:0]  awAddr = 32'h0, wData = 32'h0, arAddr = 32'h0, d;
  reg          awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0, done;
  reg  [191:0] rawCodes = 192'h0;
  reg  [3:0]   wStrb = 4'hf;
  reg  [1:0]   c;
  wire [31:0]  rData;
  wire [1:0]   bResp, rResp, ditherStrength, biasCurrentSelect;
  wire [191:0] correctedCodes;
  wire [7:0]   referenceTrim;
  wire         awReady, wReady, bValid, arReady, rValid, dataReadyPulse, amClkEn, ditherOn;
  integer      failures = 0, totalChecks = 0, cyc = 0, i, n, cnt, t0;

  // Byte strobes normally all set; one test narrows them to the trim byte
  acg_converter_global_setup u_acg_converter_global_setup (
    .clk(clk), .nrst(nrst), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
    .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
    .s_axi_rvalid(rValid), .s_axi_rready(rReady), .rawCodes(rawCodes), .correctedCodes(correctedCodes),
    .dataReadyPulse(dataReadyPulse), .analogMasterClkEn(amClkEn), .ditherOn(ditherOn),
    .ditherStrength(ditherStrength), .biasCurrentSelect(biasCurrentSelect), .referenceTrim(referenceTrim));

  always #5 clk = ~clk;
  // Cycle count for phase checks; also cuts a hang short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      failures = failures + 1;
      wrap_up;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task chk(input [31:0] got, input [31:0] exp);
    begin
      totalChecks = totalChecks + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // Bus write; each half released once taken, response compared
  task wr(input [31:0] a, input [31:0] v, input [1:0] e);
    begin
      awAddr <= a;
      wData <= v;
      awValid <= 1'b1;
      wValid <= 1'b1;
      bReady <= 1'b1;
      done = 1'b0;
      while (!done) begin
        @(posedge clk);
        if (awReady === 1'b1) awValid <= 1'b0;
        if (wReady === 1'b1) wValid <= 1'b0;
        if (bValid === 1'b1) begin
          bReady <= 1'b0;
          done = 1'b1;
          chk({30'h0, bResp}, {30'h0, e});
        end
      end
      // One idle edge so the next call never rewrites bReady in this step
      @(posedge clk);
    end
  endtask
  // Bus read with expected word and response
  task rd(input [31:0] a, input [31:0] v, input [1:0] e);
    begin
      arAddr <= a;
      arValid <= 1'b1;
      rReady <= 1'b1;
      done = 1'b0;
      while (!done) begin
        @(posedge clk);
        if (arReady === 1'b1) arValid <= 1'b0;
        if (rValid === 1'b1) begin
          rReady <= 1'b0;
          done = 1'b1;
          chk(rData, v);
          chk({30'h0, rResp}, {30'h0, e});
        end
      end
      // One idle edge so the next call never rewrites rReady in this step
      @(posedge clk);
    end
  endtask
  task waitPulse;
    begin
      @(posedge clk);
      while (dataReadyPulse !== 1'b1) @(posedge clk);
    end
  endtask
  // Every channel against raw plus offset, or raw alone
  task codes(input en);
    for (n = 0; n < 8; n = n + 1)
      chk({8'h0, correctedCodes[24 * n +: 24]},
          {8'h0, {n[2:0], 21'h4} + (en ? 24'hfffff0 + n[23:0] : 24'h0)});
  endtask
  task wrap_up;
    begin
      $display("Checks %0d, mismatches %0d", totalChecks, failures);
      if (failures == 0 && totalChecks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rd(32'h34, 32'h00386050, 2'h0);
    chk({19'h0, ditherOn, ditherStrength, biasCurrentSelect, referenceTrim}, 32'h1e50);
    wr(32'h34, 32'hffffffff, 2'h0);
    // Status word accepts a write but keeps the setup word untouched
    wr(32'h80, 32'h0, 2'h0);
    rd(32'h34, 32'h00ffe0ff, 2'h0);
    wr(32'h200, 32'h1, 2'h2);
    rd(32'h200, 32'h0, 2'h2);
    for (i = 0; i < 4; i = i + 1) begin
      c = i[1:0];
      d = {10'h0, c, ~c, 10'h0, c, ~c, c, ~c};
      wr(32'h34, d, 2'h0);
      rd(32'h34, d, 2'h0);
      chk({19'h0, ditherOn, ditherStrength, biasCurrentSelect, referenceTrim}, {19'h0, c != 2'h0, c, ~c, c, ~c, c, ~c});
    end
    // Low byte strobe only: trim changes, idle_tone_scramble_level and bias keep their codes
    wStrb <= 4'h1;
    wr(32'h34, 32'h00ffff5a, 2'h0);
    rd(32'h34, 32'h0030005a, 2'h0);
    wStrb <= 4'hf;
    $display("Test register fields done");
    // Window of 64 cycles holds a whole number of prescaler periods
    for (i = 0; i < 4; i = i + 1) begin
      wr(32'h34, {14'h0, i[1:0], 16'h0}, 2'h0);
      repeat (16) @(posedge clk);
      cnt = 0;
      repeat (64) begin
        @(posedge clk);
        if (amClkEn === 1'b1) cnt = cnt + 1;
      end
      chk(cnt, 64 >> i);
    end
    $display("Test prescaler done");
    // First pulse after a change may be early, so measure the next gap
    for (i = 0; i < 8; i = i + 1) begin
      wr(32'h34, {16'h0, i[2:0], 13'h0}, 2'h0);
      waitPulse;
      waitPulse;
      t0 = cyc;
      waitPulse;
      chk(cyc - t0, 32 << i);
    end
    $display("Test data rate done");
    for (i = 0; i < 8; i = i + 1) begin
      rawCodes[24 * i +: 24] <= {i[2:0], 21'h4};
      wr(32'h3c + 8 * i, {8'h0, 24'hfffff0 + i[23:0]}, 2'h0);
      rd(32'h3c + 8 * i, {8'h0, 24'hfffff0 + i[23:0]}, 2'h0);
    end
    wr(32'h34, 32'h0, 2'h0);
    waitPulse;
    waitPulse;
    t0 = cyc;
    codes(1'b0);
    wr(32'h34, 32'h00800000, 2'h0);
    waitPulse;
    waitPulse;
    chk((cyc - t0) % 32, 0);
    codes(1'b1);
    wr(32'h34, 32'h00c00000, 2'h0);
    waitPulse;
    waitPulse;
    chk((cyc - t0) % 32, 24);
    codes(1'b1);
    $display("Test corrections done");
    wrap_up;
  end
endmodule
